// ===== hdl/idag_defines.svh
`ifndef IDAG_DEFINES_SVH
`define IDAG_DEFINES_SVH

// ----------------------------------------
// pointer and data space
// ----------------------------------------
`define IDAG_PTR_RESET 12'h000
`define IDAG_HIGH_NIBBLE_ZERO 4'h0
`define IDAG_SFR_BASE 12'hf80
`define IDAG_STEP 12'h001

// ----------------------------------------
// register byte offsets, one aligned word each
// ----------------------------------------
`define IDAG_OFS_P0_LOW 5'h00
`define IDAG_OFS_P0_HIGH 5'h04
`define IDAG_OFS_P1_LOW 5'h08
`define IDAG_OFS_P1_HIGH 5'h0c
`define IDAG_OFS_P2_LOW 5'h10
`define IDAG_OFS_P2_HIGH 5'h14
`define IDAG_OFS_STATUS 5'h18

// ----------------------------------------
// status fields
// ----------------------------------------
`define IDAG_STAT_ADDR_LSB 0
`define IDAG_STAT_OUTSIDE_BIT 12

// ----------------------------------------
// bus answers
// ----------------------------------------
`define IDAG_RESP_OKAY 2'h0
`define IDAG_RESP_SLVERR 2'h2

`endif

// ===== hdl/idag_pkg.sv
package idag_pkg;

	// operand kind issued by the execution datapath
	typedef enum logic [2:0]
	{
		IDAG_PLAIN = 3'h0,
		IDAG_POST_DECREMENT_OPERAND = 3'h1,
		IDAG_POST_INCREMENT_OPERAND = 3'h2,
		IDAG_PRE_INCREMENT_OPERAND = 3'h3,
		IDAG_OFFSET = 3'h4
	} idag_mode_t;

	typedef logic [11:0] idag_addr_t;

endpackage

// ===== hdl/idag_pointer.sv
`timescale 1ns/1ps
`default_nettype none
`include "idag_defines.svh"

module idag_pointer
	import idag_pkg::*;
(
	input wire logic aclk, // core clock
	input wire logic aresetn, // sync reset, active low
	input wire logic load_low, // bus write of low byte
	input wire logic load_high, // bus write of high byte
	input wire logic [7:0] load_data, // byte written
	input wire logic step_en, // auto-modify this cycle
	input wire logic step_down, // 1 = decrement
	output idag_addr_t ptr // current pointer pair
);

	idag_addr_t ptr_reg;
	idag_addr_t ptr_next;

	always_comb
	begin
		ptr_next = ptr_reg;
		// bus writes beat a concurrent auto-modify
		if (load_low || load_high)
		begin
			if (load_low)
				ptr_next[7:0] = load_data;
			if (load_high)
				ptr_next[11:8] = load_data[3:0];
		end
		// (R10) whole pair steps
		// (R15) wraps in twelve bits
		else if (step_en)
			ptr_next = step_down ? ptr_reg - `IDAG_STEP : ptr_reg + `IDAG_STEP;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ptr_reg <= `IDAG_PTR_RESET;
		else
			ptr_reg <= ptr_next;
	end

	assign ptr = ptr_reg;

	// (R10) carry into high
	AST_LOW_CARRY: assert property (@(posedge aclk) disable iff (!aresetn) // (R10)
		step_en && !step_down && !load_low && !load_high && ptr_reg[7:0] == 8'hff
		|=> ptr_reg[7:0] == 8'h00 && ptr_reg[11:8] == 4'($past(ptr_reg[11:8]) + 4'h1))
		else $error("low byte rollover did not carry into high byte");

	// (R15) wrap from zero to top
	AST_WRAP_DOWN: assert property (@(posedge aclk) disable iff (!aresetn) // (R15)
		step_en && step_down && !load_low && !load_high && ptr_reg == 12'h000
		|=> ptr_reg == 12'hfff)
		else $error("decrement from zero did not wrap to the top");

endmodule // idag_pointer

`default_nettype wire

// ===== hdl/idag_ram.sv
`timescale 1ns/1ps
`default_nettype none

module idag_ram
	import idag_pkg::*;
#(
	parameter int DEPTH = 4096 // bytes behind the port
)
(
	input wire logic aclk, // core clock
	input wire logic en, // access this cycle
	input wire logic we, // write when en
	input wire idag_addr_t addr, // byte address
	input wire logic [7:0] wdata, // write byte
	output logic [7:0] rdata // registered read byte
);

	logic [7:0] mem [DEPTH];
	logic [7:0] rdata_reg;

	// no reset: contents survive every reset and power up unknown
	always_ff @(posedge aclk)
	begin
		if (en && we)
			mem[addr] <= wdata;
		rdata_reg <= (en && !we) ? mem[addr] : 8'h00;
	end

	assign rdata = rdata_reg;

endmodule // idag_ram

`default_nettype wire

// ===== hdl/idag_top.sv
// What this block does
// (R1) three pointers, each high/low byte pair
// (R2) only low nibble of high byte used
// (R3) plain operand accesses pointed location
// (R4) full pointer is address, bank ignored
// (R5) post-decrement: use pointer, then minus one
// (R6) post-increment: use pointer, then plus one
// (R7) pre-increment: plus one, then use it
// (R8) offset: pointer plus signed working register
// (R9) only auto-modify operands change pointer
// (R10) steps carry and borrow across bytes
// (R11) pointer updates touch no status flags
// (R12) virtual operands not reachable indirectly
// (R13) general RAM from zero to special area
// (R14) RAM never reset, kept across resets
// (R15) arithmetic wraps modulo 4096, nibble zero
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "idag_defines.svh"

module idag_top
	import idag_pkg::*;
#(
	parameter idag_addr_t SFR_BASE = `IDAG_SFR_BASE // first address above general RAM
)
(
	input wire logic aclk, // 25 MHz core clock
	input wire logic aresetn, // sync reset, active low
	// register bus
	input wire logic [31:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [31:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	// execution datapath
	input wire logic op_valid, // one-cycle operand access
	input wire logic [1:0] op_sel, // pointer 0..2
	input wire logic [2:0] op_mode, // idag_mode_t code
	input wire logic op_write, // 1 = write, 0 = read
	input wire logic [7:0] op_wdata, // byte to write
	input wire logic [7:0] working_reg, // working register value
	output logic op_done, // one-cycle completion
	output logic [11:0] op_addr, // address used
	output logic op_outside, // address beyond general RAM
	output logic [7:0] op_rdata // byte read
);

	// ----------------------------------------
	// pointer pairs
	// ----------------------------------------
	idag_addr_t ptr_q [3];
	logic [2:0] load_low;
	logic [2:0] load_high;
	logic [2:0] step_en;
	logic step_down;
	logic [7:0] bus_byte;

	// (R1) three independent pointer pairs
	for (genvar i = 0; i < 3; i++)
	begin : g_ptr
		idag_pointer u_ptr (
			.aclk(aclk),
			.aresetn(aresetn),
			.load_low(load_low[i]),
			.load_high(load_high[i]),
			.load_data(bus_byte),
			.step_en(step_en[i]),
			.step_down(step_down),
			.ptr(ptr_q[i])
		);
	end

	// ----------------------------------------
	// operand decode and address
	// ----------------------------------------
	logic op_fire;
	idag_addr_t cur_ptr;
	idag_addr_t addr_calc;
	idag_addr_t w_ext;
	logic do_step;
	logic outside;

	assign op_fire = op_valid && op_sel != 2'h3;
	assign cur_ptr = (op_sel == 2'h3) ? `IDAG_PTR_RESET : ptr_q[op_sel];
	// (R15) sign-extend keeps offset in twelve bits
	assign w_ext = {{4{working_reg[7]}}, working_reg};

	always_comb
	begin
		addr_calc = cur_ptr;
		do_step = 1'b0;
		step_down = 1'b0;
		// (R4) full pointer, no banking
		unique case (op_mode)
			IDAG_PLAIN:
				// (R3) (R9) pointer left alone
				addr_calc = cur_ptr;
			IDAG_POST_DECREMENT_OPERAND:
			begin
				// (R5) old value, then down
				do_step = 1'b1;
				step_down = 1'b1;
			end
			IDAG_POST_INCREMENT_OPERAND:
				// (R6) old value, then up
				do_step = 1'b1;
			IDAG_PRE_INCREMENT_OPERAND:
			begin
				// (R7) new value used
				addr_calc = cur_ptr + `IDAG_STEP;
				do_step = 1'b1;
			end
			IDAG_OFFSET:
				// (R8) pointer and working register unchanged
				addr_calc = cur_ptr + w_ext;
			default:
				addr_calc = cur_ptr;
		endcase
	end

	// (R11) steps go to the pointer only, no flag path exists
	always_comb
	begin
		step_en = 3'h0;
		if (op_fire && do_step)
			step_en[op_sel] = 1'b1;
	end

	// (R13) general RAM below the special area
	// (R12) above it nothing is served, so no operand chains
	assign outside = addr_calc >= SFR_BASE;

	// ----------------------------------------
	// general RAM
	// ----------------------------------------
	// (R14) memory has no reset path
	idag_ram #(
		.DEPTH(4096)
	) u_ram (
		.aclk(aclk),
		.en(op_fire && !outside),
		.we(op_write),
		.addr(addr_calc),
		.wdata(op_wdata),
		.rdata(op_rdata)
	);

	logic op_done_reg, op_done_next;
	idag_addr_t op_addr_reg, op_addr_next;
	logic op_outside_reg, op_outside_next;

	always_comb
	begin
		op_done_next = op_fire;
		op_addr_next = op_fire ? addr_calc : op_addr_reg;
		op_outside_next = op_fire ? outside : op_outside_reg;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			op_done_reg <= 1'b0;
			op_addr_reg <= `IDAG_PTR_RESET;
			op_outside_reg <= 1'b0;
		end
		else
		begin
			op_done_reg <= op_done_next;
			op_addr_reg <= op_addr_next;
			op_outside_reg <= op_outside_next;
		end
	end

	assign op_done = op_done_reg;
	assign op_addr = op_addr_reg;
	assign op_outside = op_outside_reg;

	// ----------------------------------------
	// register bus slave
	// ----------------------------------------
	logic awready_reg, awready_next;
	logic wready_reg, wready_next;
	logic aw_hold_reg, aw_hold_next;
	logic w_hold_reg, w_hold_next;
	logic [4:0] awofs_reg, awofs_next;
	logic aw_bad_reg, aw_bad_next;
	logic [7:0] wbyte_reg, wbyte_next;
	logic wlane_reg, wlane_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic do_write;
	logic [31:0] rd_mux;
	logic rd_bad;

	assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign bus_byte = wbyte_reg;

	// (R2) high byte loads only its low nibble
	always_comb
	begin
		load_low = 3'h0;
		load_high = 3'h0;
		if (do_write && wlane_reg && !aw_bad_reg)
		begin
			unique case (awofs_reg)
				`IDAG_OFS_P0_LOW: load_low[0] = 1'b1;
				`IDAG_OFS_P0_HIGH: load_high[0] = 1'b1;
				`IDAG_OFS_P1_LOW: load_low[1] = 1'b1;
				`IDAG_OFS_P1_HIGH: load_high[1] = 1'b1;
				`IDAG_OFS_P2_LOW: load_low[2] = 1'b1;
				`IDAG_OFS_P2_HIGH: load_high[2] = 1'b1;
				default: load_low = 3'h0;
			endcase
		end
	end

	// high bytes read their unused nibble as zero
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		rd_bad = s_axi_araddr[31:5] != 27'h0 || s_axi_araddr[1:0] != 2'h0;
		unique case (s_axi_araddr[4:0])
			`IDAG_OFS_P0_LOW: rd_mux[7:0] = ptr_q[0][7:0];
			`IDAG_OFS_P0_HIGH: rd_mux[7:0] = {`IDAG_HIGH_NIBBLE_ZERO, ptr_q[0][11:8]};
			`IDAG_OFS_P1_LOW: rd_mux[7:0] = ptr_q[1][7:0];
			`IDAG_OFS_P1_HIGH: rd_mux[7:0] = {`IDAG_HIGH_NIBBLE_ZERO, ptr_q[1][11:8]};
			`IDAG_OFS_P2_LOW: rd_mux[7:0] = ptr_q[2][7:0];
			`IDAG_OFS_P2_HIGH: rd_mux[7:0] = {`IDAG_HIGH_NIBBLE_ZERO, ptr_q[2][11:8]};
			`IDAG_OFS_STATUS:
			begin
				rd_mux[`IDAG_STAT_ADDR_LSB +: 12] = op_addr_reg;
				rd_mux[`IDAG_STAT_OUTSIDE_BIT] = op_outside_reg;
			end
			default: rd_bad = 1'b1;
		endcase
	end

	always_comb
	begin
		aw_hold_next = aw_hold_reg;
		awofs_next = awofs_reg;
		aw_bad_next = aw_bad_reg;
		w_hold_next = w_hold_reg;
		wbyte_next = wbyte_reg;
		wlane_next = wlane_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid && awready_reg)
		begin
			aw_hold_next = 1'b1;
			awofs_next = s_axi_awaddr[4:0];
			aw_bad_next = s_axi_awaddr[31:5] != 27'h0 || s_axi_awaddr[4:0] > `IDAG_OFS_STATUS
				|| s_axi_awaddr[1:0] != 2'h0;
		end
		if (s_axi_wvalid && wready_reg)
		begin
			w_hold_next = 1'b1;
			wbyte_next = s_axi_wdata[7:0];
			wlane_next = s_axi_wstrb[0];
		end
		// status is read-only: a write there is answered and ignored
		if (do_write)
		begin
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = aw_bad_reg ? `IDAG_RESP_SLVERR : `IDAG_RESP_OKAY;
		end
		else if (bvalid_reg && s_axi_bready)
			bvalid_next = 1'b0;
		awready_next = !aw_hold_next && !bvalid_next;
		wready_next = !w_hold_next && !bvalid_next;
	end

	always_comb
	begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_arvalid && arready_reg)
		begin
			rvalid_next = 1'b1;
			rdata_next = rd_bad ? 32'h0000_0000 : rd_mux;
			rresp_next = rd_bad ? `IDAG_RESP_SLVERR : `IDAG_RESP_OKAY;
		end
		else if (rvalid_reg && s_axi_rready)
			rvalid_next = 1'b0;
		arready_next = !rvalid_next;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awofs_reg <= 5'h00;
			aw_bad_reg <= 1'b0;
			wbyte_reg <= 8'h00;
			wlane_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `IDAG_RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `IDAG_RESP_OKAY;
		end
		else
		begin
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			awofs_reg <= awofs_next;
			aw_bad_reg <= aw_bad_next;
			wbyte_reg <= wbyte_next;
			wlane_reg <= wlane_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic quiet;
	assign quiet = load_low == 3'h0 && load_high == 3'h0;

	AST_PLAIN_ADDR: assert property (@(posedge aclk) disable iff (!aresetn) // (R3)
		op_fire && op_mode == IDAG_PLAIN |=> op_done_reg && op_addr_reg == $past(cur_ptr))
		else $error("plain operand did not use the pointer as address");

	AST_PLAIN_KEEP: assert property (@(posedge aclk) disable iff (!aresetn) // (R9)
		op_fire && op_mode == IDAG_PLAIN && quiet |=> ptr_q[$past(op_sel)] == $past(cur_ptr))
		else $error("plain operand changed the pointer");

	AST_POST_DECREMENT_OPERAND: assert property (@(posedge aclk) disable iff (!aresetn) // (R5)
		op_fire && op_mode == IDAG_POST_DECREMENT_OPERAND && quiet
		|=> op_addr_reg == $past(cur_ptr) && ptr_q[$past(op_sel)] == 12'($past(cur_ptr) - 12'h001))
		else $error("post-decrement address or update wrong");

	AST_POST_INCREMENT_OPERAND: assert property (@(posedge aclk) disable iff (!aresetn) // (R6)
		op_fire && op_mode == IDAG_POST_INCREMENT_OPERAND && quiet
		|=> op_addr_reg == $past(cur_ptr) && ptr_q[$past(op_sel)] == 12'($past(cur_ptr) + 12'h001))
		else $error("post-increment address or update wrong");

	AST_PRE_INCREMENT_OPERAND: assert property (@(posedge aclk) disable iff (!aresetn) // (R7)
		op_fire && op_mode == IDAG_PRE_INCREMENT_OPERAND && quiet
		|=> op_addr_reg == ptr_q[$past(op_sel)] && op_addr_reg == 12'($past(cur_ptr) + 12'h001))
		else $error("pre-increment did not address the updated pointer");

	AST_OFFSET: assert property (@(posedge aclk) disable iff (!aresetn) // (R8)
		op_fire && op_mode == IDAG_OFFSET && quiet
		|=> op_addr_reg == 12'($past(cur_ptr) + {{4{$past(working_reg[7])}}, $past(working_reg)})
		&& ptr_q[$past(op_sel)] == $past(cur_ptr))
		else $error("offset operand address wrong or pointer moved");

	AST_OUTSIDE_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn) // (R12)
		op_done_reg && op_outside_reg |-> op_rdata == 8'h00 && op_addr_reg >= SFR_BASE)
		else $error("access beyond general RAM returned data");

	AST_BUS_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn) // (R1)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid [*1] ##0 s_axi_rdata[31:12] == 20'h0
		|| s_axi_rresp == `IDAG_RESP_OKAY)
		else $error("read answer missing one cycle after address");

	AST_HIGH_NIBBLE: assert property (@(posedge aclk) disable iff (!aresetn) // (R2)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h0000_0004
		|=> s_axi_rdata[31:4] == 28'h0 && s_axi_rdata[3:0] == $past(ptr_q[0][11:8]))
		else $error("high byte readback wrong");

endmodule // idag_top

`default_nettype wire

// ===== tb/idag_exec_model.sv
`timescale 1ns/1ps
`default_nettype none

module idag_exec_model
	import idag_pkg::*;
(
	input wire logic aclk, // core clock
	input wire logic req, // issue one operand access
	input wire logic [1:0] req_sel, // pointer 0..2
	input wire logic [2:0] req_mode, // operand kind
	input wire logic req_write, // 1 = write
	input wire logic [7:0] req_wdata, // byte to write
	input wire logic [7:0] req_wreg, // working register
	output logic op_valid, // to block
	output logic [1:0] op_sel, // to block
	output logic [2:0] op_mode, // to block
	output logic op_write, // to block
	output logic [7:0] op_wdata, // to block
	output logic [7:0] working_reg, // to block
	input wire logic op_done, // from block
	input wire logic [11:0] op_addr, // from block
	input wire logic op_outside, // from block
	input wire logic [7:0] op_rdata, // from block
	output logic [7:0] res_count, // results taken so far
	output logic [11:0] res_addr, // last address seen
	output logic res_outside, // last outside flag
	output logic [7:0] res_rdata // last byte seen
);
	initial
	begin
		op_valid = 1'b0;
		op_sel = 2'h3;
		op_mode = 3'h0;
		op_write = 1'b0;
		op_wdata = 8'h00;
		working_reg = 8'h00;
		res_count = 8'h00;
		res_addr = 12'h000;
		res_outside = 1'b0;
		res_rdata = 8'h00;
	end

	// idle cycles toggle the data lines so stale values never look valid
	always @(posedge aclk)
	begin
		op_valid <= req;
		op_sel <= req ? req_sel : 2'h3;
		op_mode <= req_mode;
		op_write <= req ? req_write : ~op_write;
		op_wdata <= req ? req_wdata : ~op_wdata;
		working_reg <= req ? req_wreg : ~working_reg;
		if (op_done)
		begin
			res_count <= res_count + 8'h01;
			res_addr <= op_addr;
			res_outside <= op_outside;
			res_rdata <= op_rdata;
		end
	end
endmodule // idag_exec_model

`default_nettype wire

// ===== tb/indirect_data_address_gen_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "idag_defines.svh"

module indirect_data_address_gen_bench
	import idag_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, op_valid, op_write, op_done, op_outside;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, op_sel;
	logic [2:0] op_mode;
	logic [7:0] op_wdata, working_reg, op_rdata, res_count, res_rdata;
	logic [11:0] op_addr, res_addr;
	logic res_outside;
	logic req = 1'b0, req_write = 1'b0;
	logic [1:0] req_sel = 2'h0;
	logic [2:0] req_mode = 3'h0;
	logic [7:0] req_wdata = 8'h00, req_wreg = 8'h00;
	logic [31:0] d;
	logic [1:0] r;
	logic [15:0] p;
	int mismatches = 0;
	int check_count = 0;

	always #20 aclk = ~aclk;

	idag_top dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.op_valid(op_valid), .op_sel(op_sel), .op_mode(op_mode), .op_write(op_write),
		.op_wdata(op_wdata), .working_reg(working_reg), .op_done(op_done),
		.op_addr(op_addr), .op_outside(op_outside), .op_rdata(op_rdata));

	idag_exec_model core (.aclk(aclk), .req(req), .req_sel(req_sel), .req_mode(req_mode),
		.req_write(req_write), .req_wdata(req_wdata), .req_wreg(req_wreg),
		.op_valid(op_valid), .op_sel(op_sel), .op_mode(op_mode), .op_write(op_write),
		.op_wdata(op_wdata), .working_reg(working_reg), .op_done(op_done),
		.op_addr(op_addr), .op_outside(op_outside), .op_rdata(op_rdata),
		.res_count(res_count), .res_addr(res_addr), .res_outside(res_outside),
		.res_rdata(res_rdata));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic hang();
		mismatches++;
		$display("mismatch at %0t: wait ran out", $time);
		end_of_test();
	endtask

	task automatic reset_dut(input int n);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (n) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	// master holds each channel until its own ready is seen at an edge
	task automatic axi_write(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		logic aw_done, w_done;
		n = 0;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (awvalid && awready) aw_done = 1'b1;
			if (wvalid && wready) w_done = 1'b1;
			if (aw_done) awvalid <= 1'b0;
			if (w_done) wvalid <= 1'b0;
			if (++n > 50) hang();
		end
		do
		begin
			@(posedge aclk);
			if (++n > 100) hang();
		end
		while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (++n > 50) hang();
		end
		while (!arready);
		arvalid <= 1'b0;
		do
		begin
			@(posedge aclk);
			if (++n > 100) hang();
		end
		while (!rvalid);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	task automatic wr(input int a, input int v);
		logic [1:0] rs;
		axi_write(32'(a), 32'(v), rs);
	endtask

	// high byte in 15:8 so unused upper bits are checked too
	task automatic get_ptr(input int s, output logic [15:0] v);
		logic [31:0] lo, hi;
		logic [1:0] rs;
		axi_read(32'(s * 8), lo, rs);
		axi_read(32'(s * 8 + 4), hi, rs);
		v = {hi[7:0], lo[7:0]};
	endtask

	task automatic op(input int s, input idag_mode_t m, input logic w, input int wd, input int wr_v);
		int n;
		logic [7:0] c;
		c = res_count;
		n = 0;
		@(posedge aclk);
		req <= 1'b1;
		req_sel <= 2'(s);
		req_mode <= m;
		req_write <= w;
		req_wdata <= 8'(wd);
		req_wreg <= 8'(wr_v);
		@(posedge aclk);
		req <= 1'b0;
		while (res_count === c)
		begin
			@(posedge aclk);
			if (++n > 10) hang();
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		reset_dut(16);
		for (int i = 0; i < 3; i++)
		begin
			wr(i * 8, 'h10 + i);
			wr(i * 8 + 4, 'hf0 + i);
		end
		for (int i = 0; i < 3; i++)
		begin
			get_ptr(i, p);
			chk(32'(p), 32'(i * 256 + 'h10 + i));
		end
		wr(0, 'hff);
		wr(4, 'h3a);
		get_ptr(0, p);
		chk(32'(p), 32'h0aff);
		op(0, IDAG_PLAIN, 1'b1, 'h5c, 'h55);
		chk(32'(res_addr), 32'haff);
		get_ptr(0, p);
		chk(32'(p), 32'h0aff);
		op(0, IDAG_POST_INCREMENT_OPERAND, 1'b0, 0, 0);
		chk(32'(res_addr), 32'haff);
		chk(32'(res_rdata), 32'h5c);
		get_ptr(0, p);
		chk(32'(p), 32'h0b00);
		op(0, IDAG_POST_DECREMENT_OPERAND, 1'b0, 0, 0);
		chk(32'(res_addr), 32'hb00);
		get_ptr(0, p);
		chk(32'(p), 32'h0aff);
		op(0, IDAG_PRE_INCREMENT_OPERAND, 1'b1, 'h77, 0);
		chk(32'(res_addr), 32'hb00);
		op(0, IDAG_PLAIN, 1'b0, 0, 0);
		chk(32'(res_rdata), 32'h77);
		op(0, IDAG_OFFSET, 1'b0, 0, 'h80);
		chk(32'(res_addr), 32'ha80);
		op(0, IDAG_OFFSET, 1'b0, 0, 'h7f);
		chk(32'(res_addr), 32'hb7f);
		get_ptr(0, p);
		chk(32'(p), 32'h0b00);
		wr(8, 0);
		wr(12, 0);
		op(1, IDAG_OFFSET, 1'b1, 'h33, 'hff);
		chk(32'({res_outside, res_addr}), 32'h1fff);
		op(1, IDAG_POST_DECREMENT_OPERAND, 1'b0, 0, 0);
		get_ptr(1, p);
		chk(32'(p), 32'h0fff);
		op(1, IDAG_POST_INCREMENT_OPERAND, 1'b0, 0, 0);
		chk(32'({res_outside, res_rdata}), 32'h100);
		get_ptr(1, p);
		chk(32'(p), 32'h0000);
		axi_read(32'h18, d, r);
		chk(d, 32'h1fff);
		wr(16, 'h7f);
		wr(20, 'h0f);
		op(2, IDAG_PLAIN, 1'b1, 'h42, 0);
		op(2, IDAG_POST_INCREMENT_OPERAND, 1'b0, 0, 0);
		chk(32'({res_outside, res_rdata}), 32'h042);
		op(2, IDAG_PLAIN, 1'b0, 0, 0);
		chk(32'({res_outside, res_addr}), 32'(`IDAG_SFR_BASE) | 32'h1000);
		axi_write(32'h1c, 32'h0, r);
		chk(32'(r), 32'(`IDAG_RESP_SLVERR));
		axi_read(32'h1c, d, r);
		chk({d[29:0], r}, 32'(`IDAG_RESP_SLVERR));
		wr(0, 'h10);
		wr(4, 0);
		op(0, IDAG_PLAIN, 1'b1, 'ha5, 0);
		reset_dut(4);
		wr(0, 'h10);
		op(0, IDAG_PLAIN, 1'b0, 0, 0);
		chk(32'(res_rdata), 32'ha5);
		end_of_test();
	end

	initial
	begin
		#3000000;
		hang();
	end
endmodule // indirect_data_address_gen_bench

`default_nettype wire
